// ===== xmi_pkg.sv
// Purpose: Shared constants for the external data memory interface
// Assumes: APB register window with one aligned 32-bit word per register
// Notes:   Registers hold up to 8 bits in the low byte, upper bits read as zero
package xmi_pkg;

  localparam int APB_AW = 8;

  // Register byte offsets
  localparam logic [APB_AW-1:0] OFF_PAGE = 8'h00;
  localparam logic [APB_AW-1:0] OFF_CFG  = 8'h04;
  localparam logic [APB_AW-1:0] OFF_TIM  = 8'h08;
  localparam logic [APB_AW-1:0] OFF_STAT = 8'h0c;

  // Values after reset, plus the CFG write mask
  localparam logic [7:0] PAGE_RST = 8'h00;
  localparam logic [7:0] CFG_RST  = 8'h03;
  localparam logic [7:0] TIM_RST  = 8'hff;
  localparam logic [7:0] CFG_WMSK = 8'h3f;

  // Field positions
  localparam int CFG_PRT_BIT = 5;
  localparam int CFG_MUX_BIT = 4;
  localparam int CFG_MOD_LSB = 2;
  localparam int CFG_ALE_LSB = 0;
  localparam int TIM_SU_LSB  = 6;
  localparam int TIM_STB_LSB = 2;
  localparam int TIM_HLD_LSB = 0;

  // Memory mode field encodings
  localparam logic [1:0] MODE_INT   = 2'b00;
  localparam logic [1:0] MODE_SPLIT = 2'b01;
  localparam logic [1:0] MODE_BANK  = 2'b10;
  localparam logic [1:0] MODE_EXT   = 2'b11;

  // On-chip XRAM
  localparam int          XRAM_AW    = 12;
  localparam logic [16:0] XRAM_BYTES = 17'h01000;

  // Off-chip cycle overhead: one decode cycle plus a closing tail
  localparam int         OVH_CYC   = 4;
  localparam int         START_CYC = 1;
  localparam logic [3:0] FIN_LOAD  = 4'(OVH_CYC - START_CYC - 1);

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0000,
    ST_XRAM  = 4'b0001,
    ST_START = 4'b0010,
    ST_ALEH  = 4'b0011,
    ST_ALEL  = 4'b0100,
    ST_SETUP = 4'b0101,
    ST_STRB  = 4'b0110,
    ST_HOLD  = 4'b0111,
    ST_FIN   = 4'b1000
  } xmi_state_e;

endpackage

// ===== xmi_xram.sv
// Purpose: On-chip XRAM, single port, registered read
// Assumes: One access per cycle, write and read share the address
// Notes:   Read data appears one edge after the address
`timescale 1ns/10ps
module xmi_xram #(
  parameter int AW = 12,
  parameter int DW = 8
) (
  input  wire logic          ref_clk_i,
  input  wire logic          we_i,
  input  wire logic [AW-1:0] addr_i,
  input  wire logic [DW-1:0] wdata_i,
  output logic      [DW-1:0] rdata_o
);

  logic [DW-1:0] mem_r [0:(1<<AW)-1];

  // No reset on the array; contents are undefined until written
  always_ff @(posedge ref_clk_i) begin
    if (we_i) begin
      mem_r[addr_i] <= wdata_i;
    end
    rdata_o <= mem_r[addr_i];
  end

endmodule

// ===== xmi_top.sv
// Purpose: External data memory interface with on-chip XRAM and APB registers
// Assumes: CPU request pulse with operands held in the same cycle
// Notes:   Pin drivers here are claims only; port latches sit outside
`timescale 1ns/10ps
module xmi_top (
  input  wire logic                       ref_clk_i,
  input  wire logic                       nrst_i,
  input  wire logic                       psel_i,
  input  wire logic                       penable_i,
  input  wire logic                       pwrite_i,
  input  wire logic [xmi_pkg::APB_AW-1:0] paddr_i,
  input  wire logic [31:0]                pwdata_i,
  input  wire logic [3:0]                 pstrb_i,
  output logic      [31:0]                prdata_o,
  output logic                            pready_o,
  output logic                            pslverr_o,
  input  wire logic                       mov_req_i,
  input  wire logic                       mov_wr_i,
  input  wire logic                       mov_wide_i,
  input  wire logic [15:0]                data_pointer_i,
  input  wire logic [7:0]                 idx_i,
  input  wire logic [7:0]                 mov_wdata_i,
  output logic                            mov_busy_o,
  output logic                            mov_done_o,
  output logic      [7:0]                 mov_rdata_o,
  output logic                            pins_claim_o,
  output logic      [7:0]                 ext_ahi_o,
  output logic                            ext_ahi_oe_o,
  output logic      [7:0]                 ext_alo_o,
  output logic                            ext_alo_oe_o,
  output logic      [7:0]                 ext_ad_o,
  output logic                            ext_ad_oe_o,
  input  wire logic [7:0]                 ext_ad_i,
  output logic                            ale_o,
  output logic                            rd_n_o,
  output logic                            wr_n_o
);
  import xmi_pkg::*;

  logic [7:0]  page_r;
  logic [7:0]  cfg_r;
  logic [7:0]  tim_r;
  xmi_state_e  state_r;
  xmi_state_e  state_nxt;
  logic [3:0]  cnt_r;
  logic [3:0]  cnt_nxt;
  logic [15:0] eff_addr;
  logic        off_dec;
  logic        accept;
  logic [15:0] op_addr_r;
  logic [7:0]  op_data_r;
  logic        op_wr_r;
  logic        op_wide_r;
  logic        op_nmux_r;
  logic        op_prt_r;
  logic [1:0]  op_mode_r;
  logic [1:0]  op_ale_r;
  logic [7:0]  op_tim_r;
  logic [1:0]  op_su;
  logic [1:0]  op_hld;
  logic        off_nxt;
  logic        claim_nxt;
  logic [7:0]  xram_q;
  logic        apb_wr;
  logic [7:0]  rd_mux;
  logic        unmapped;

  // APB slave: answer in the first access cycle
  assign unmapped = !(paddr_i inside {OFF_PAGE, OFF_CFG, OFF_TIM, OFF_STAT});
  assign apb_wr   = psel_i && penable_i && pready_o && pwrite_i && !pslverr_o && pstrb_i[0];

  always_comb begin
    case (paddr_i)
      OFF_PAGE: rd_mux = page_r;
      OFF_CFG:  rd_mux = cfg_r & CFG_WMSK;
      OFF_TIM:  rd_mux = tim_r;
      OFF_STAT: rd_mux = {6'h00, state_r >= ST_START, state_r != ST_IDLE};
      default:  rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0000_0000;
    end else begin
      pready_o  <= psel_i && !penable_i;
      pslverr_o <= psel_i && !penable_i && unmapped;
      prdata_o  <= {24'h00_0000, rd_mux};
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      page_r <= PAGE_RST;
      cfg_r  <= CFG_RST;
      tim_r  <= TIM_RST;
    end else if (apb_wr) begin
      case (paddr_i)
        OFF_PAGE: page_r <= pwdata_i[7:0];
        OFF_CFG:  cfg_r  <= pwdata_i[7:0] & CFG_WMSK;
        OFF_TIM:  tim_r  <= pwdata_i[7:0];
        default:  page_r <= page_r;
      endcase
    end
  end

  // Address forming and target decode
  assign eff_addr = mov_wide_i ? data_pointer_i : {page_r, idx_i};

  always_comb begin
    case (cfg_r[CFG_MOD_LSB +: 2])
      MODE_INT:   off_dec = 1'b0;
      MODE_SPLIT: off_dec = {1'b0, eff_addr} >= XRAM_BYTES;
      MODE_BANK:  off_dec = {1'b0, eff_addr} >= XRAM_BYTES;
      MODE_EXT:   off_dec = 1'b1;
      default:    off_dec = 1'b0;
    endcase
  end

  assign accept = mov_req_i && (state_r == ST_IDLE);

  // Operands and settings frozen per move so register writes cannot tear it
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      op_addr_r <= 16'h0000;
      op_data_r <= 8'h00;
      op_wr_r   <= 1'b0;
      op_wide_r <= 1'b0;
      op_nmux_r <= 1'b0;
      op_prt_r  <= 1'b0;
      op_mode_r <= MODE_INT;
      op_ale_r  <= 2'b00;
      op_tim_r  <= TIM_RST;
    end else if (accept) begin
      op_addr_r <= eff_addr;
      op_data_r <= mov_wdata_i;
      op_wr_r   <= mov_wr_i;
      op_wide_r <= mov_wide_i;
      op_nmux_r <= cfg_r[CFG_MUX_BIT];
      op_prt_r  <= cfg_r[CFG_PRT_BIT];
      op_mode_r <= cfg_r[CFG_MOD_LSB +: 2];
      op_ale_r  <= cfg_r[CFG_ALE_LSB +: 2];
      op_tim_r  <= tim_r;
    end
  end

  assign op_su  = op_tim_r[TIM_SU_LSB +: 2];
  assign op_hld = op_tim_r[TIM_HLD_LSB +: 2];

  // On-chip XRAM; upper address bits dropped so access wraps at 4 kB
  xmi_xram #(
    .AW (XRAM_AW),
    .DW (8)
  ) u_xram (
    .ref_clk_i (ref_clk_i),
    .we_i      (accept && !off_dec && mov_wr_i),
    .addr_i    (eff_addr[XRAM_AW-1:0]),
    .wdata_i   (mov_wdata_i),
    .rdata_o   (xram_q)
  );

  // Off-chip sequencer; zero-length setup and hold phases are skipped
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = (cnt_r != 4'h0) ? cnt_r - 4'h1 : 4'h0;
    if (cnt_r == 4'h0) begin
      case (state_r)
        ST_IDLE: begin
          if (mov_req_i) begin
            state_nxt = off_dec ? ST_START : ST_XRAM;
          end
        end
        ST_XRAM:  state_nxt = ST_IDLE;
        ST_START: state_nxt = !op_nmux_r ? ST_ALEH : (op_su != 2'b00) ? ST_SETUP : ST_STRB;
        ST_ALEH:  state_nxt = ST_ALEL;
        ST_ALEL:  state_nxt = (op_su != 2'b00) ? ST_SETUP : ST_STRB;
        ST_SETUP: state_nxt = ST_STRB;
        ST_STRB:  state_nxt = (op_hld != 2'b00) ? ST_HOLD : ST_FIN;
        ST_HOLD:  state_nxt = ST_FIN;
        ST_FIN:   state_nxt = ST_IDLE;
        default:  state_nxt = ST_IDLE;
      endcase
      case (state_nxt)
        ST_ALEH:  cnt_nxt = {2'b00, op_ale_r};
        ST_ALEL:  cnt_nxt = {2'b00, op_ale_r};
        ST_SETUP: cnt_nxt = {2'b00, op_su - 2'b01};
        ST_STRB:  cnt_nxt = op_tim_r[TIM_STB_LSB +: 4];
        ST_HOLD:  cnt_nxt = {2'b00, op_hld - 2'b01};
        ST_FIN:   cnt_nxt = FIN_LOAD;
        default:  cnt_nxt = 4'h0;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      state_r <= ST_IDLE;
      cnt_r   <= 4'h0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

  // Pins claimed only after the decode cycle, released at the end of the tail
  assign off_nxt   = state_nxt inside {ST_ALEH, ST_ALEL, ST_SETUP, ST_STRB, ST_HOLD, ST_FIN};
  assign claim_nxt = off_nxt && op_prt_r && (op_mode_r != MODE_INT);

  // Only pin values and enables leave here; push-pull or open-drain is set outside
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      pins_claim_o <= 1'b0;
      ext_ahi_o    <= 8'h00;
      ext_ahi_oe_o <= 1'b0;
      ext_alo_o    <= 8'h00;
      ext_alo_oe_o <= 1'b0;
      ext_ad_o     <= 8'h00;
      ext_ad_oe_o  <= 1'b0;
      ale_o        <= 1'b0;
      rd_n_o       <= 1'b1;
      wr_n_o       <= 1'b1;
    end else begin
      pins_claim_o <= claim_nxt;
      ext_ahi_o    <= op_addr_r[15:8];
      ext_ahi_oe_o <= claim_nxt && (op_wide_r || op_mode_r == MODE_BANK);
      ext_alo_o    <= op_addr_r[7:0];
      ext_alo_oe_o <= claim_nxt && op_nmux_r;
      ale_o        <= claim_nxt && (state_nxt == ST_ALEH);
      rd_n_o       <= !(claim_nxt && state_nxt == ST_STRB && !op_wr_r);
      wr_n_o       <= !(claim_nxt && state_nxt == ST_STRB && op_wr_r);
      if (!op_nmux_r && state_nxt inside {ST_ALEH, ST_ALEL}) begin
        ext_ad_o    <= op_addr_r[7:0];
        ext_ad_oe_o <= claim_nxt;
      end else begin
        ext_ad_o    <= op_data_r;
        ext_ad_oe_o <= claim_nxt && op_wr_r;
      end
    end
  end

  // CPU answer: done pulse with read data one edge after the last cycle
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      mov_done_o  <= 1'b0;
      mov_busy_o  <= 1'b0;
      mov_rdata_o <= 8'h00;
    end else begin
      mov_done_o <= (state_r == ST_XRAM) || (state_r == ST_FIN && cnt_r == 4'h0);
      mov_busy_o <= state_nxt != ST_IDLE;
      if (state_r == ST_XRAM && !op_wr_r) begin
        mov_rdata_o <= xram_q;
      end else if (state_r == ST_STRB && cnt_r == 4'h0 && !op_wr_r) begin
        mov_rdata_o <= op_prt_r ? ext_ad_i : 8'hff;
      end
    end
  end

  // Checking helpers
  logic [3:0] ale_hi_cnt;
  logic [5:0] oc_cnt;
  logic [5:0] oc_want;

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      ale_hi_cnt <= 4'h0;
      oc_cnt     <= 6'h00;
    end else begin
      ale_hi_cnt <= ale_o ? ale_hi_cnt + 4'h1 : 4'h0;
      oc_cnt     <= (state_r >= ST_START) ? oc_cnt + 6'h01 : 6'h00;
    end
  end

  assign oc_want = 6'(OVH_CYC) + {4'h0, op_su} + {2'h0, op_tim_r[TIM_STB_LSB +: 4]} + 6'h01
                 + {4'h0, op_hld} + (op_nmux_r ? 6'h00 : ({4'h0, op_ale_r} + 6'h01) * 6'h02);

  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);

  a_idle_no_claim: assert property (state_r == ST_IDLE |-> !pins_claim_o)
    else $error("Pins claimed while idle");
  a_read_no_drive: assert property (!rd_n_o |-> !ext_ad_oe_o && pins_claim_o)
    else $error("Data pins driven during a read strobe");
  a_int_no_claim: assert property ($rose(pins_claim_o) |-> op_mode_r != MODE_INT)
    else $error("Pins claimed in internal-only mode");
  a_ale_mux_only: assert property (ale_o |-> !op_nmux_r && !ext_alo_oe_o)
    else $error("Latch enable outside multiplexed mode");
  a_ale_width: assert property ($fell(ale_o) |-> ale_hi_cnt == {2'b00, op_ale_r} + 4'h1)
    else $error("Latch enable high time wrong");
  a_ale_then_strobe: assert property ($fell(ale_o) |-> rd_n_o && wr_n_o ##0 ext_ad_oe_o)
    else $error("Strobe overlaps latch enable");
  a_offchip_len: assert property (state_r == ST_FIN && cnt_r == 4'h0 |-> oc_cnt + 6'h01 == oc_want)
    else $error("Off-chip move length wrong");
  a_hi_addr_drive: assert property (pins_claim_o |-> ext_ahi_oe_o == (op_wide_r || op_mode_r == MODE_BANK))
    else $error("Upper address drive wrong");
  a_split_decode: assert property (state_r == ST_START && op_mode_r != MODE_EXT |-> op_addr_r >= 16'h1000)
    else $error("Low address sent off-chip in split mode");
  a_xram_no_pins: assert property (state_r == ST_XRAM |=> !pins_claim_o && rd_n_o && wr_n_o)
    else $error("Pins touched during on-chip access");

endmodule

// ===== xmi_sram_model.sv
// Purpose: Off-chip byte memory with address latch for the interface
// Assumes: Pins already resolved to wire levels by the bench
// Notes:   Contents preset from the address so reads prove the address
`timescale 1ns/10ps
module xmi_sram_model (
  input  wire logic       ref_clk_i,
  input  wire logic       mux_i,
  input  wire logic [7:0] ahi_i,
  input  wire logic [7:0] alo_i,
  input  wire logic [7:0] ad_i,
  input  wire logic       ad_oe_i,
  input  wire logic       ale_i,
  input  wire logic       rd_n_i,
  input  wire logic       wr_n_i,
  output logic      [7:0] ad_o
);
  logic [7:0]  mem_r [65536];
  logic [7:0]  lat_r;
  logic [7:0]  last_r;
  logic [15:0] a_w;
  logic        drv_w;
  initial begin
    last_r = 8'h00;
    for (int i = 0; i < 65536; i++) begin
      mem_r[i] = i[7:0] ^ i[15:8] ^ 8'h3c;
    end
  end
  // Transparent while high, frozen from the falling edge
  always_latch begin
    if (ale_i) lat_r = ad_i;
  end
  assign a_w   = {ahi_i, mux_i ? lat_r : alo_i};
  assign drv_w = !rd_n_i && !ad_oe_i;
  // Released bus shows the inverse of the last byte, never a stale copy
  assign ad_o  = drv_w ? mem_r[a_w] : ~last_r;
  always @(posedge ref_clk_i) begin
    if (!wr_n_i) mem_r[a_w] <= ad_i;
    if (drv_w) last_r <= mem_r[a_w];
  end
endmodule

// ===== tb.sv
// Purpose: Self-checking bench for the external data memory interface
// Assumes: Port latches parked at logic one, so undriven address pins read 1
// Notes:   Each move is watched cycle by cycle from request to done
`timescale 1ns/10ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("unexpected %s exp %h seen %h", nm, e, g); end end
module tb;
  import xmi_pkg::*;
  logic        ref_clk_i, nrst_i, psel_i, penable_i, pwrite_i;
  logic        mov_req_i, mov_wr_i, mov_wide_i, mux_m;
  logic        pready_o, pslverr_o, mov_busy_o, mov_done_o, pins_claim_o;
  logic        ext_ahi_oe_o, ext_alo_oe_o, ext_ad_oe_o, ale_o, rd_n_o, wr_n_o;
  logic [7:0]  paddr_i, idx_i, mov_wdata_i, mov_rdata_o, rv, mdl_ad;
  logic [7:0]  ext_ahi_o, ext_alo_o, ext_ad_o, ahi_w, alo_w, ad_w;
  logic [15:0] data_pointer_i;
  logic [31:0] pwdata_i, prdata_o, pr;
  logic [3:0]  pstrb_i;
  logic        pe, cl_s, ah_s, al_s, bad_s, st_s, bz_s;
  int          n_mismatch, num_checks, n_cyc, n_ale;
  assign ahi_w = ext_ahi_oe_o ? ext_ahi_o : 8'hff;
  assign alo_w = ext_alo_oe_o ? ext_alo_o : 8'hff;
  assign ad_w  = ext_ad_oe_o ? ext_ad_o : mdl_ad;
  xmi_top i_xmi_top (.ref_clk_i, .nrst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
    .pwdata_i, .pstrb_i, .prdata_o, .pready_o, .pslverr_o, .mov_req_i, .mov_wr_i,
    .mov_wide_i, .data_pointer_i, .idx_i, .mov_wdata_i, .mov_busy_o, .mov_done_o,
    .mov_rdata_o, .pins_claim_o, .ext_ahi_o, .ext_ahi_oe_o, .ext_alo_o,
    .ext_alo_oe_o, .ext_ad_o, .ext_ad_oe_o, .ext_ad_i(ad_w), .ale_o, .rd_n_o,
    .wr_n_o);
  xmi_sram_model i_xmi_sram_model (.ref_clk_i, .mux_i(mux_m), .ahi_i(ahi_w),
    .alo_i(alo_w), .ad_i(ad_w), .ad_oe_i(ext_ad_oe_o), .ale_i(ale_o),
    .rd_n_i(rd_n_o), .wr_n_i(wr_n_o), .ad_o(mdl_ad));
  function automatic logic [7:0] f(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h3c;
  endfunction
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    psel_i    <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i  <= w;
    paddr_i   <= a;
    pwdata_i  <= d;
    @(posedge ref_clk_i);
    penable_i <= 1'b1;
    do @(posedge ref_clk_i); while (pready_o !== 1'b1);
    pr = prdata_o;
    pe = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] x, input string nm);
    apb(1'b0, a, 32'h0);
    `CHK(nm, {24'h0, x}, pr)
  endtask
  task automatic mov(input logic w, wd, input logic [15:0] dp, input logic [7:0] ix, wv);
    @(posedge ref_clk_i);
    mov_req_i   <= 1'b1;
    mov_wr_i    <= w;
    mov_wide_i  <= wd;
    data_pointer_i      <= dp;
    idx_i       <= ix;
    mov_wdata_i <= wv;
    @(posedge ref_clk_i);
    mov_req_i <= 1'b0;
    n_cyc = 0;
    n_ale = 0;
    {cl_s, ah_s, al_s, bad_s, st_s, bz_s} = '0;
    #1;
    while (mov_done_o !== 1'b1) begin
      n_cyc++;
      n_ale += int'(ale_o === 1'b1);
      cl_s |= pins_claim_o;
      ah_s |= ext_ahi_oe_o;
      al_s |= ext_alo_oe_o;
      st_s |= !rd_n_o || !wr_n_o;
      bz_s |= !mov_busy_o;
      bad_s |= (!rd_n_o && ext_ad_oe_o) || (!wr_n_o && !ext_ad_oe_o);
      @(posedge ref_clk_i);
      #1;
    end
    rv = mov_rdata_o;
    `CHK("claim at done", 1'b0, pins_claim_o)
    `CHK("busy gap", 1'b0, bz_s)
    `CHK("busy at done", 1'b0, mov_busy_o)
  endtask
  task automatic t_regs();
    rd(OFF_PAGE, PAGE_RST, "page reset");
    rd(OFF_CFG, CFG_RST, "cfg reset");
    rd(OFF_TIM, TIM_RST, "timing reset");
    rd(OFF_STAT, 8'h00, "status idle");
    pstrb_i <= 4'he;
    wr(OFF_PAGE, 8'h55);
    pstrb_i <= 4'hf;
    rd(OFF_PAGE, PAGE_RST, "strobe off write");
    wr(OFF_CFG, 8'hff);
    rd(OFF_CFG, CFG_WMSK, "cfg mask");
    apb(1'b0, 8'h10, 32'h0);
    `CHK("unmapped err", 1'b1, pe)
    `CHK("unmapped data", 32'h0, pr)
  endtask
  task automatic t_int();
    wr(OFF_CFG, 8'h30);
    mov(1'b1, 1'b1, 16'h1234, 8'h00, 8'h5a);
    mov(1'b0, 1'b1, 16'h0234, 8'h00, 8'h00);
    `CHK("wrap read", 8'h5a, rv)
    `CHK("int cycles", 1, n_cyc)
    `CHK("int claim", 1'b0, cl_s)
    `CHK("int strobe", 1'b0, st_s)
    wr(OFF_PAGE, 8'h22);
    mov(1'b0, 1'b0, 16'h0000, 8'h34, 8'h00);
    `CHK("paged read", 8'h5a, rv)
  endtask
  task automatic t_split();
    wr(OFF_TIM, 8'h00);
    wr(OFF_CFG, 8'h34);
    mov(1'b0, 1'b1, 16'h0234, 8'h00, 8'h00);
    `CHK("low on-chip", 8'h5a, rv)
    `CHK("low claim", 1'b0, cl_s)
    mov(1'b0, 1'b1, 16'h1234, 8'h00, 8'h00);
    `CHK("high off-chip", f(16'h1234), rv)
    `CHK("min cycles", 5, n_cyc)
    `CHK("wide upper oe", 1'b1, ah_s)
    `CHK("off claim", 1'b1, cl_s)
    `CHK("low pins oe", 1'b1, al_s)
    `CHK("input drivers", 1'b0, bad_s)
    wr(OFF_PAGE, 8'h12);
    mov(1'b0, 1'b0, 16'h0000, 8'h56, 8'h00);
    `CHK("nobank read", f(16'hff56), rv)
    `CHK("nobank upper", 1'b0, ah_s)
  endtask
  task automatic t_bank();
    wr(OFF_CFG, 8'h38);
    wr(OFF_TIM, 8'h45);
    mov(1'b1, 1'b0, 16'h0000, 8'h56, 8'h77);
    `CHK("timed cycles", 8, n_cyc)
    `CHK("write drivers", 1'b0, bad_s)
    mov(1'b0, 1'b1, 16'h1256, 8'h00, 8'h00);
    `CHK("bank address", 8'h77, rv)
    mov(1'b0, 1'b0, 16'h0000, 8'h56, 8'h00);
    `CHK("bank upper oe", 1'b1, ah_s)
  endtask
  task automatic t_ext();
    wr(OFF_CFG, 8'h3c);
    mov(1'b0, 1'b1, 16'h0234, 8'h00, 8'h00);
    `CHK("ext low read", f(16'h0234), rv)
    `CHK("ext claim", 1'b1, cl_s)
    mov(1'b0, 1'b0, 16'h0000, 8'h34, 8'h00);
    `CHK("ext 8bit read", f(16'hff34), rv)
    `CHK("ext upper oe", 1'b0, ah_s)
  endtask
  task automatic t_mux();
    wr(OFF_TIM, 8'h00);
    wr(OFF_CFG, 8'h2d);
    mux_m = 1'b1;
    mov(1'b0, 1'b1, 16'h1234, 8'h00, 8'h00);
    `CHK("mux read", f(16'h1234), rv)
    `CHK("ale high", 2, n_ale)
    `CHK("mux cycles", 9, n_cyc)
    `CHK("mux low pins", 1'b0, al_s)
    mov(1'b1, 1'b1, 16'h1300, 8'h00, 8'h99);
    `CHK("mux drivers", 1'b0, bad_s)
    mov(1'b0, 1'b1, 16'h1300, 8'h00, 8'h00);
    `CHK("mux write", 8'h99, rv)
    wr(OFF_CFG, 8'h1c);
    mov(1'b0, 1'b1, 16'h1234, 8'h00, 8'h00);
    `CHK("port off read", 8'hff, rv)
    `CHK("port off claim", 1'b0, cl_s)
  endtask
  initial begin
    ref_clk_i = 1'b0;
    forever #2.5 ref_clk_i = ~ref_clk_i;
  end
  // Whole run is well under two thousand cycles
  initial begin
    #100000;
    n_mismatch++;
    print_verdict();
  end
  initial begin
    {psel_i, penable_i, pwrite_i, mov_req_i, mov_wr_i, mov_wide_i, mux_m} = '0;
    {paddr_i, idx_i, mov_wdata_i, data_pointer_i, pwdata_i} = '0;
    pstrb_i = 4'hf;
    n_mismatch = 0;
    num_checks = 0;
    nrst_i = 1'b0;
    repeat (10) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    t_regs();
    t_int();
    t_split();
    t_bank();
    t_ext();
    t_mux();
    print_verdict();
  end
endmodule
